/* lasi_pkg.sv */
package lasi_pkg;
	// Register indices; the byte address is four times the index
	localparam logic [11:0] IDX_IRQ_EN    = 12'hF04;
	localparam logic [11:0] IDX_STATUS    = 12'hF05;
	localparam logic [11:0] IDX_CHANGES   = 12'hF07;
	localparam logic [13:0] ADDR_IRQ_EN   = {IDX_IRQ_EN, 2'h0};
	localparam logic [13:0] ADDR_STATUS   = {IDX_STATUS, 2'h0};
	localparam logic [13:0] ADDR_CHANGES  = {IDX_CHANGES, 2'h0};
	// Enable register fields
	localparam int BIT_PATTERN_IE = 0;
	localparam int BIT_LOSS_IE    = 1;
	localparam int BIT_FIFO_IE    = 5;
	localparam int BIT_DMON_IE    = 6;
	localparam logic [7:0] IRQ_EN_MASK  = 8'h63;
	localparam logic [7:0] IRQ_EN_RESET = 8'h00;
	// Status register fields
	localparam int BIT_PATTERN_ST = 0;
	localparam int BIT_LOSS_ST    = 1;
	localparam int BIT_FIFO_ST    = 5;
	localparam int BIT_DMON_ST    = 6;
	localparam logic [7:0] STATUS_MASK = 8'h63;
	// Driver monitor silence length in bit periods
	localparam int          DMON_BITS    = 128;
	localparam logic [7:0]  DMON_LIMIT   = 8'(DMON_BITS);
	// FIFO limit window in bits
	localparam logic [7:0]  FIFO_WINDOW  = 8'h03;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage

/* lasi_alarm_irq.sv */
`timescale 1ns/1ns
`default_nettype none
// Contract
// - SIGNAL_LOSS_DEFECT declare and clear interrupt when enabled; the code raises it only in single-rail mode
// - Pattern detect start/stop interrupt when enabled; the code raises it only in single-rail mode
// - DMO alarm after 128 silent bit periods
// - DMO alarm clears at once on pulse
// - Status bit 6 shows DMO alarm
// - DMO transitions interrupt when bit 6 enabled; the code raises it only in single-rail mode
// - Status bit 5: FIFO pointers within three
// - FIFO flag transitions interrupt when enabled; the code raises it only in single-rail mode
// - Status bits 7 and 4 read zero
module lasi_alarm_irq (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Line side
	input  wire logic        bit_en_i,
	input  wire logic        tx_line_pos_i,
	input  wire logic        tx_line_neg_i,
	input  wire logic        signal_loss_defect_i,
	input  wire logic        pattern_detect_i,
	input  wire logic [7:0]  fifo_wr_ptr_i,
	input  wire logic [7:0]  fifo_rd_ptr_i,
	input  wire logic        single_rail_i,
	// AXI4-Lite write
	input  wire logic [13:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [13:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Interrupt event
	output logic             irq_o
);

	// Pin synchronisers
	logic [1:0] pos_s_q, neg_s_q, los_s_q, pat_s_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pos_s_q <= 2'h0;
			neg_s_q <= 2'h0;
			los_s_q <= 2'h0;
			pat_s_q <= 2'h0;
		end else begin
			pos_s_q <= {pos_s_q[0], tx_line_pos_i};
			neg_s_q <= {neg_s_q[0], tx_line_neg_i};
			los_s_q <= {los_s_q[0], signal_loss_defect_i};
			pat_s_q <= {pat_s_q[0], pattern_detect_i};
		end
	end

	// Driver monitor: counts silent bit periods
	logic [7:0] silent_q;
	logic       dmon_q;
	logic       pulse_seen;
	assign pulse_seen = pos_s_q[1] | neg_s_q[1];
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			silent_q <= 8'h00;
			dmon_q   <= 1'b0;
		end else if (pulse_seen) begin
			silent_q <= 8'h00;
			dmon_q   <= 1'b0;
		end else if (bit_en_i) begin
			if (silent_q == lasi_pkg::DMON_LIMIT - 8'h01) begin
				dmon_q <= 1'b1;
			end else begin
				silent_q <= silent_q + 8'h01;
			end
		end
	end

	// FIFO limit: pointers within the window either way
	logic [7:0] ptr_diff;
	logic       fifo_lim_q;
	assign ptr_diff = fifo_wr_ptr_i - fifo_rd_ptr_i;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fifo_lim_q <= 1'b0;
		end else begin
			fifo_lim_q <= (ptr_diff <= lasi_pkg::FIFO_WINDOW) ||
				((8'h00 - ptr_diff) <= lasi_pkg::FIFO_WINDOW);
		end
	end

	// Status word; unused bits tie to zero
	logic [7:0] status;
	always_comb begin
		status = 8'h00;
		status[lasi_pkg::BIT_PATTERN_ST] = pat_s_q[1];
		status[lasi_pkg::BIT_LOSS_ST]    = los_s_q[1];
		status[lasi_pkg::BIT_FIFO_ST]    = fifo_lim_q;
		status[lasi_pkg::BIT_DMON_ST]    = dmon_q;
	end

	// Change detection against previous cycle
	logic [7:0] status_prev_q;
	logic [7:0] changes;
	logic [7:0] irq_en_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_prev_q <= 8'h00;
		end else begin
			status_prev_q <= status;
		end
	end
	assign changes = (status ^ status_prev_q) & lasi_pkg::STATUS_MASK;

	// One-cycle interrupt pulse per enabled change; gated by single-rail mode
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= single_rail_i && (changes & irq_en_q) != 8'h00;
		end
	end

	// Sticky change log, readable and write-one-to-clear; set wins
	logic [7:0] seen_q;
	logic       wr_fire;
	logic [13:0] aw_q;
	logic [31:0] w_q;
	logic [3:0]  ws_q;
	logic        aw_have_q, w_have_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			seen_q <= 8'h00;
		end else if (wr_fire && aw_q == lasi_pkg::ADDR_CHANGES && ws_q[0]) begin
			seen_q <= (seen_q & ~w_q[7:0]) | changes;
		end else begin
			seen_q <= seen_q | changes;
		end
	end

	// AXI write path: address and data taken in either order
	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
	assign wr_fire       = aw_have_q && w_have_q && !s_axi_bvalid;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_q      <= 14'h0000;
			w_q       <= 32'h0000_0000;
			ws_q      <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_q      <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_have_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				w_q      <= s_axi_wdata;
				ws_q     <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_have_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_en_q <= lasi_pkg::IRQ_EN_RESET;
		end else if (wr_fire && aw_q == lasi_pkg::ADDR_IRQ_EN && ws_q[0]) begin
			irq_en_q <= w_q[7:0] & lasi_pkg::IRQ_EN_MASK;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= lasi_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			if (aw_q == lasi_pkg::ADDR_IRQ_EN || aw_q == lasi_pkg::ADDR_CHANGES) begin
				s_axi_bresp <= lasi_pkg::RESP_OKAY;
			end else begin
				s_axi_bresp <= lasi_pkg::RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// AXI read path: one read in flight
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= lasi_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= lasi_pkg::RESP_OKAY;
			if (s_axi_araddr == lasi_pkg::ADDR_IRQ_EN) begin
				s_axi_rdata <= {24'h000000, irq_en_q};
			end else if (s_axi_araddr == lasi_pkg::ADDR_STATUS) begin
				s_axi_rdata <= {24'h000000, status};
			end else if (s_axi_araddr == lasi_pkg::ADDR_CHANGES) begin
				s_axi_rdata <= {24'h000000, seen_q};
			end else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= lasi_pkg::RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Checks
	a_dmon_declare: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(dmon_q) |-> $past(silent_q) == lasi_pkg::DMON_LIMIT - 8'h01 && $past(bit_en_i))
		else $error("driver alarm rose early");
	a_dmon_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		pulse_seen |=> !dmon_q)
		else $error("driver alarm not cleared");
	a_status_dmon: assert property (@(posedge clk_i) disable iff (rst_i)
		status[lasi_pkg::BIT_DMON_ST] == dmon_q)
		else $error("status bit 6 wrong");
	a_fifo_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(fifo_wr_ptr_i) == $past(fifo_rd_ptr_i) |-> status[lasi_pkg::BIT_FIFO_ST])
		else $error("fifo flag missing");
	a_unused_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		status[7] == 1'b0 && status[4] == 1'b0)
		else $error("unused status bit set");
	a_loss_irq: assert property (@(posedge clk_i) disable iff (rst_i)
		single_rail_i && irq_en_q[lasi_pkg::BIT_LOSS_IE] && $changed(los_s_q[1]) |=> irq_o)
		else $error("loss change lost");
	a_pat_irq: assert property (@(posedge clk_i) disable iff (rst_i)
		single_rail_i && irq_en_q[lasi_pkg::BIT_PATTERN_IE] && $changed(pat_s_q[1]) |=> irq_o)
		else $error("pattern change lost");
	a_dmon_irq: assert property (@(posedge clk_i) disable iff (rst_i)
		single_rail_i && irq_en_q[lasi_pkg::BIT_DMON_IE] && $changed(dmon_q) |=> irq_o)
		else $error("driver change lost");
	a_fifo_irq: assert property (@(posedge clk_i) disable iff (rst_i)
		single_rail_i && irq_en_q[lasi_pkg::BIT_FIFO_IE] && $changed(fifo_lim_q) |=> irq_o)
		else $error("fifo change lost");
	a_irq_cause: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_o |-> $past((changes & irq_en_q) != 8'h00))
		else $error("interrupt without cause");
	c_dmon_set: cover property (@(posedge clk_i) disable iff (rst_i) $rose(dmon_q));
	c_irq: cover property (@(posedge clk_i) disable iff (rst_i) irq_o);
	c_write: cover property (@(posedge clk_i) disable iff (rst_i) wr_fire);
	c_read: cover property (@(posedge clk_i) disable iff (rst_i) s_axi_rvalid && s_axi_rready);
	c_fifo_set: cover property (@(posedge clk_i) disable iff (rst_i) $rose(fifo_lim_q));

	// Gating and masking
	// Outside single-rail mode the registers stay readable, but no event escapes
	a_rail_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		!single_rail_i |=> !irq_o)
		else $error("interrupt outside single rail");
	a_irq_disabled: assert property (@(posedge clk_i) disable iff (rst_i)
		(changes & irq_en_q) == 8'h00 |=> !irq_o)
		else $error("interrupt while disabled");
	a_en_mask: assert property (@(posedge clk_i) disable iff (rst_i)
		(irq_en_q & ~lasi_pkg::IRQ_EN_MASK) == 8'h00)
		else $error("reserved enable bit set");

	// Alarm internals
	// Counter parks one short of the limit, so it never wraps in long silence
	a_dmon_count: assert property (@(posedge clk_i) disable iff (rst_i)
		silent_q <= lasi_pkg::DMON_LIMIT - 8'h01)
		else $error("silence counter overran");
	a_fifo_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		ptr_diff > lasi_pkg::FIFO_WINDOW && (8'h00 - ptr_diff) > lasi_pkg::FIFO_WINDOW |=> !fifo_lim_q)
		else $error("fifo flag without limit");
	// Change log keeps every change even when a clear lands in the same cycle
	a_seen_sets: assert property (@(posedge clk_i) disable iff (rst_i)
		changes != 8'h00 |=> (seen_q & $past(changes)) == $past(changes))
		else $error("change log dropped an event");

	// Bus handshakes
	a_bvalid_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rvalid_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read response dropped");
	a_rdata_upper: assert property (@(posedge clk_i) disable iff (rst_i)
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	// Only one write may be outstanding
	a_wr_ready: assert property (@(posedge clk_i) disable iff (rst_i)
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");

endmodule
`default_nettype wire

/* lasi_line_model.sv */
`timescale 1ns/1ns
`default_nettype none
module lasi_line_model (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Commands from the bench
	input  wire logic       silent_i,
	input  wire logic [7:0] gap_i,
	// Line side
	output logic            bit_en_o,
	output logic            tx_line_pos_o,
	output logic            tx_line_neg_o,
	output logic [7:0]      fifo_wr_ptr_o,
	output logic [7:0]      fifo_rd_ptr_o,
	output logic            single_rail_o
);
	logic [1:0] div_q;
	logic       mark_q;
	assign single_rail_o = 1'b1;
	assign fifo_rd_ptr_o = fifo_wr_ptr_o - gap_i;
	// Four clocks a bit period keeps the silent run short
	always_ff @(posedge clk_i) begin
		div_q         <= rst_i ? 2'h0 : div_q + 2'h1;
		bit_en_o      <= !rst_i && div_q == 2'h3;
		fifo_wr_ptr_o <= rst_i ? 8'h00 : fifo_wr_ptr_o + {7'h00, bit_en_o};
	end
	// Alternate mark polarity, one mark each bit period
	always_ff @(posedge clk_i) begin
		tx_line_pos_o <= !rst_i && !silent_i && div_q == 2'h3 && mark_q;
		tx_line_neg_o <= !rst_i && !silent_i && div_q == 2'h3 && !mark_q;
		mark_q        <= rst_i ? 1'b0 : mark_q ^ (div_q == 2'h3);
	end
endmodule
`default_nettype wire

/* liu_alarm_status_interrupts_test.sv */
`timescale 1ns/1ns
`default_nettype none
module liu_alarm_status_interrupts_test;
	localparam logic [13:0] EN = lasi_pkg::ADDR_IRQ_EN;
	localparam logic [13:0] ST = lasi_pkg::ADDR_STATUS;
	localparam logic [1:0]  OK = lasi_pkg::RESP_OKAY;
	logic        clk, rst, silent, signal_loss_defect, pat, ben, pos, neg, sr, irq;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [7:0]  gap, wp, rp;
	logic [13:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	int          bad_count, samples_checked, irq_n, base;
	lasi_line_model model_u (.clk_i(clk), .rst_i(rst), .silent_i(silent), .gap_i(gap), .bit_en_o(ben),
		.tx_line_pos_o(pos), .tx_line_neg_o(neg), .fifo_wr_ptr_o(wp), .fifo_rd_ptr_o(rp), .single_rail_o(sr));
	lasi_alarm_irq dut_u (.clk_i(clk), .rst_i(rst), .bit_en_i(ben), .tx_line_pos_i(pos), .tx_line_neg_i(neg),
		.signal_loss_defect_i(signal_loss_defect), .pattern_detect_i(pat), .fifo_wr_ptr_i(wp), .fifo_rd_ptr_i(rp),
		.single_rail_i(sr), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_o(irq));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		if (irq === 1'b1) irq_n <= irq_n + 1;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Readies are sampled mid-cycle, since inputs only move at rising edges
	task automatic wr(input logic [13:0] a, input logic [7:0] d);
		logic ta, tw, tb;
		tb = 1'b0;
		awaddr  <= a;
		wdata   <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (!tb) begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid === 1'b1;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		chk("bresp", 32'(OK), 32'(bresp));
		@(posedge clk);
	endtask
	task automatic rdchk(input logic [13:0] a, input logic [31:0] e, input logic [1:0] er);
		logic ta, t;
		logic [31:0] d;
		logic [1:0] r;
		t = 1'b0;
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		while (!t) begin
			@(negedge clk);
			ta = arvalid && arready;
			t = rvalid === 1'b1;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		chk("rdata", e, d);
		chk("rresp", 32'(er), 32'(r));
		@(posedge clk);
	endtask
	task automatic t_regs;
		rdchk(EN, 32'h0, OK);
		rdchk(ST, 32'h0, OK);
		rdchk(14'h0000, 32'h0, lasi_pkg::RESP_SLVERR);
		wr(EN, 8'hFF);
		rdchk(EN, 32'h63, OK);
		$display("regs done");
	endtask
	task automatic t_dmon;
		wr(EN, 8'h40);
		base = irq_n;
		silent <= 1'b1;
		repeat (480) @(posedge clk);
		rdchk(ST, 32'h0, OK);
		repeat (48) @(posedge clk);
		rdchk(ST, 32'h40, OK);
		silent <= 1'b0;
		repeat (12) @(posedge clk);
		rdchk(ST, 32'h0, OK);
		chk("irq", 2, irq_n - base);
		$display("dmon done");
	endtask
	task automatic t_rx;
		wr(EN, 8'h02);
		base = irq_n;
		signal_loss_defect <= 1'b1;
		repeat (8) @(posedge clk);
		rdchk(ST, 32'h02, OK);
		signal_loss_defect <= 1'b0;
		pat <= 1'b1;
		repeat (8) @(posedge clk);
		rdchk(ST, 32'h01, OK);
		chk("irq", 2, irq_n - base);
		wr(EN, 8'h01);
		base = irq_n;
		pat <= 1'b0;
		repeat (8) @(posedge clk);
		chk("irq", 1, irq_n - base);
		$display("rx done");
	endtask
	task automatic t_fifo;
		wr(EN, 8'h20);
		base = irq_n;
		gap <= 8'h03;
		repeat (8) @(posedge clk);
		rdchk(ST, 32'h20, OK);
		gap <= 8'h04;
		repeat (8) @(posedge clk);
		rdchk(ST, 32'h0, OK);
		chk("irq", 2, irq_n - base);
		$display("fifo done");
	endtask
	task automatic report_and_stop;
		$display("Checked %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		{rst, silent, signal_loss_defect, pat, gap, awaddr, araddr, wdata} = {1'b1, 3'h0, 8'h08, 14'h0, 14'h0, 32'h0};
		{awvalid, wvalid, bready, arvalid, rready, irq_n, bad_count, samples_checked} = '0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_dmon();
		t_rx();
		t_fifo();
		report_and_stop();
	end
	// Whole run is under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		report_and_stop();
	end
endmodule
`default_nettype wire
